/* File: data_req_pkg.sv */
// Package for the data send request checker: field widths, encodings,
// register offsets and reset values.
// Assumes one 25 MHz clock domain and a plain strobe register port.
`default_nettype none
package data_req_pkg;
	// Address kinds
	localparam logic [1:0] ADDR_NONE     = 2'h0;
	localparam logic [1:0] ADDR_RESERVED = 2'h1;
	localparam logic [1:0] ADDR_SHORT    = 2'h2;
	localparam logic [1:0] ADDR_EXT      = 2'h3;
	// Network identifier mask
	localparam logic [15:0] NET_ID_MASK  = 16'hFCFF;
	// Protection levels, key select method, key slot and priority limits
	localparam logic [7:0] PROT_NONE     = 8'h00;
	localparam logic [7:0] PROT_ENC_MIC32 = 8'h05;
	localparam logic [7:0] KEY_METHOD_OK = 8'h01;
	localparam logic [7:0] KEY_SLOT_MAX  = 8'h01;
	localparam logic [7:0] PRIO_MAX      = 8'h01;
	// Payload limit default
	localparam logic [7:0] MAX_PAYLOAD_RESET = 8'hFF;
	// Send flag bit positions
	localparam int SEND_ACK_BIT = 0;
	// Outcome codes
	localparam logic [1:0] OUTCOME_OK      = 2'h0;
	localparam logic [1:0] OUTCOME_INVALID = 2'h1;
	// Register offsets
	localparam logic [3:0] REG_MAX_PAYLOAD = 4'h0;
	localparam logic [3:0] REG_STATUS      = 4'h1;
	localparam logic [3:0] REG_IRQ_ENABLE  = 4'h2;
	localparam logic [3:0] REG_IRQ_CLEAR   = 4'h3;
	localparam logic [3:0] REG_COUNTS      = 4'h4;
	localparam logic [3:0] REG_LAST        = 4'h5;
	// Status bit positions
	localparam int ST_ACCEPT = 0;
	localparam int ST_REJECT = 1;
	localparam int ST_WIDTH  = 2;
	localparam logic [ST_WIDTH-1:0] IRQ_EN_RESET = 2'h0;
endpackage : data_req_pkg
`default_nettype wire

/* File: data_req_checker.sv */
// Data send request checker: validates and decodes one request per cycle.
// Assumes requests arrive as a one-cycle strobe with all fields valid,
// and the payload itself travels beside this block, tagged the same way.
//
// Behaviour
// - Source kind 0 means no address, 2 short, 3 extended, and 1 is reserved.
// - Destination kind shares that encoding and sizes the destination address as empty, 16 or 64 bits.
// - The destination network id is ANDed with FCFF before use, clearing bits 8 and 9.
// - The payload tag travels with the request so the outcome can be matched to it.
// - Bit 0 of the 3-bit send flags selects unacknowledged (0) or acknowledged (1) sending.
// - Priority class accepts only 0 (normal) and 1 (high).
// - Protection level accepts only 0 (none) and 5 (encrypt with 32-bit check).
// - Key select method must be 1 when protection is on and is ignored when it is off.
// - Key slot accepts only 0 and 1.
//
// The address-and-strobe port and the address map were chosen for this implementation.
`default_nettype none
module data_req_checker
(
	// Clock, reset, enable
	input  wire logic        clk,
	input  wire logic        arst_n,
	input  wire logic        clk_en,
	// Request from the upper layer
	input  wire logic        data_send_request,
	input  wire logic [1:0]  source_addr_kind,
	input  wire logic [1:0]  dest_addr_kind,
	input  wire logic [15:0] dest_network_id,
	input  wire logic [63:0] dest_node_addr,
	input  wire logic [7:0]  payload_octet_count,
	input  wire logic [7:0]  payload_tag,
	input  wire logic [2:0]  send_flags,
	input  wire logic [7:0]  priority_class,
	input  wire logic [7:0]  protection_level,
	input  wire logic [7:0]  key_select_method,
	input  wire logic [7:0]  key_slot,
	// Decoded request towards framing
	output logic             out_valid,
	output logic             out_reject,
	output logic [1:0]       out_outcome,
	output logic [7:0]       out_tag,
	output logic [1:0]       out_source_kind,
	output logic [1:0]       out_dest_kind,
	output logic [15:0]      out_network_id,
	output logic [63:0]      out_node_addr,
	output logic [7:0]       out_octet_count,
	output logic             out_ack_mode,
	output logic             out_high_prio,
	output logic             out_encrypt,
	output logic             out_key_slot,
	// Register port
	input  wire logic [3:0]  reg_addr,
	input  wire logic [31:0] reg_wdata,
	input  wire logic        reg_write,
	input  wire logic        reg_read,
	output logic [31:0]      reg_rdata,
	// Interrupt
	output logic             irq
);

	// Kind decoding used for both addresses
	function automatic logic kind_legal(input logic [1:0] kind);
		kind_legal = (kind != data_req_pkg::ADDR_RESERVED);
	endfunction

	// Width-limited address view; a short address keeps only the low 16 bits
	function automatic logic [63:0] addr_view(input logic [1:0] kind, input logic [63:0] addr);
		unique case (kind)
			data_req_pkg::ADDR_SHORT: addr_view = {48'h0, addr[15:0]};
			data_req_pkg::ADDR_EXT:   addr_view = addr;
			default:                  addr_view = 64'h0;
		endcase
	endfunction

	logic [7:0]                       max_payload_q;
	logic [data_req_pkg::ST_WIDTH-1:0] status_q;
	logic [data_req_pkg::ST_WIDTH-1:0] irq_en_q;
	logic [15:0]                      accept_cnt_q;
	logic [15:0]                      reject_cnt_q;

	// Field checks, all combinational
	logic src_ok;
	logic dst_ok;
	logic prio_ok;
	logic prot_ok;
	logic prot_on;
	logic method_ok;
	logic slot_ok;
	logic len_ok;
	logic req_ok;

	assign src_ok    = kind_legal(source_addr_kind);
	assign dst_ok    = kind_legal(dest_addr_kind);
	assign prio_ok   = (priority_class <= data_req_pkg::PRIO_MAX);
	assign prot_on   = (protection_level == data_req_pkg::PROT_ENC_MIC32);
	assign prot_ok   = (protection_level == data_req_pkg::PROT_NONE) || prot_on;
	// Method only counts while protection is on
	assign method_ok = !prot_on || (key_select_method == data_req_pkg::KEY_METHOD_OK);
	assign slot_ok   = (key_slot <= data_req_pkg::KEY_SLOT_MAX);
	// Length check guards against a requester breaking its own limit
	assign len_ok    = (payload_octet_count <= max_payload_q);
	assign req_ok    = src_ok && dst_ok && prio_ok && prot_ok && method_ok && slot_ok && len_ok;

	// Decoded outputs, one cycle after the request
	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			out_valid       <= 1'b0;
			out_reject      <= 1'b0;
			out_outcome     <= data_req_pkg::OUTCOME_OK;
			out_tag         <= 8'h00;
			out_source_kind <= data_req_pkg::ADDR_NONE;
			out_dest_kind   <= data_req_pkg::ADDR_NONE;
			out_network_id  <= 16'h0000;
			out_node_addr   <= 64'h0;
			out_octet_count <= 8'h00;
			out_ack_mode    <= 1'b0;
			out_high_prio   <= 1'b0;
			out_encrypt     <= 1'b0;
			out_key_slot    <= 1'b0;
		end
		else if (clk_en)
		begin
			out_valid  <= data_send_request && req_ok;
			out_reject <= data_send_request && !req_ok;
			if (data_send_request)
			begin
				out_outcome     <= req_ok ? data_req_pkg::OUTCOME_OK : data_req_pkg::OUTCOME_INVALID;
				out_tag         <= payload_tag;
				out_source_kind <= source_addr_kind;
				out_dest_kind   <= dest_addr_kind;
				out_network_id  <= dest_network_id & data_req_pkg::NET_ID_MASK;
				out_node_addr   <= addr_view(dest_addr_kind, dest_node_addr);
				out_octet_count <= payload_octet_count;
				// Reserved flag bits are simply not looked at
				out_ack_mode    <= send_flags[data_req_pkg::SEND_ACK_BIT];
				out_high_prio   <= priority_class[0];
				out_encrypt     <= prot_on;
				// Slot is meaningless without protection, so it reads zero then
				out_key_slot    <= prot_on & key_slot[0];
			end
		end
	end

	// Maximum payload size register
	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
			max_payload_q <= data_req_pkg::MAX_PAYLOAD_RESET;
		else if (clk_en && reg_write && reg_addr == data_req_pkg::REG_MAX_PAYLOAD)
			max_payload_q <= reg_wdata[7:0];
	end

	// Interrupt enable register
	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
			irq_en_q <= data_req_pkg::IRQ_EN_RESET;
		else if (clk_en && reg_write && reg_addr == data_req_pkg::REG_IRQ_ENABLE)
			irq_en_q <= reg_wdata[data_req_pkg::ST_WIDTH-1:0];
	end

	// Sticky status; a new event beats a clear in the same cycle
	logic [data_req_pkg::ST_WIDTH-1:0] ev;
	logic [data_req_pkg::ST_WIDTH-1:0] clr;
	assign ev[data_req_pkg::ST_ACCEPT] = data_send_request && req_ok;
	assign ev[data_req_pkg::ST_REJECT] = data_send_request && !req_ok;
	assign clr = (reg_write && reg_addr == data_req_pkg::REG_IRQ_CLEAR) ?
		reg_wdata[data_req_pkg::ST_WIDTH-1:0] : '0;

	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
			status_q <= '0;
		else if (clk_en)
			status_q <= (status_q & ~clr) | ev;
	end

	// Request counters, wrap at full scale
	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			accept_cnt_q <= 16'h0000;
			reject_cnt_q <= 16'h0000;
		end
		else if (clk_en)
		begin
			if (ev[data_req_pkg::ST_ACCEPT])
				accept_cnt_q <= accept_cnt_q + 16'h0001;
			if (ev[data_req_pkg::ST_REJECT])
				reject_cnt_q <= reject_cnt_q + 16'h0001;
		end
	end

	// Interrupt level, registered
	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
			irq <= 1'b0;
		else if (clk_en)
			irq <= |(((status_q & ~clr) | ev) & irq_en_q);
	end

	// Read data, valid only the cycle after the strobe
	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
			reg_rdata <= 32'h0000_0000;
		else if (clk_en)
		begin
			reg_rdata <= 32'h0000_0000;
			if (reg_read)
			begin
				unique case (reg_addr)
					data_req_pkg::REG_MAX_PAYLOAD: reg_rdata <= {24'h0, max_payload_q};
					data_req_pkg::REG_STATUS:      reg_rdata <= {30'h0, status_q};
					data_req_pkg::REG_IRQ_ENABLE:  reg_rdata <= {30'h0, irq_en_q};
					data_req_pkg::REG_COUNTS:      reg_rdata <= {reject_cnt_q, accept_cnt_q};
					data_req_pkg::REG_LAST:        reg_rdata <= {14'h0, out_outcome, 8'h00, out_tag};
					default:                       reg_rdata <= 32'h0000_0000;
				endcase
			end
		end
	end

endmodule // data_req_checker
`default_nettype wire

/* File: req_source.sv */
// Upper-layer model: issues data send requests one cycle long.
// Assumes one clock; the bench calls send from procedural code.
`default_nettype none
module req_source
(
	// Clock
	input  wire logic   clk,
	// Request fields
	output logic        data_send_request,
	output logic [1:0]  source_addr_kind,
	output logic [1:0]  dest_addr_kind,
	output logic [15:0] dest_network_id,
	output logic [63:0] dest_node_addr,
	output logic [7:0]  payload_octet_count,
	output logic [7:0]  payload_tag,
	output logic [2:0]  send_flags,
	output logic [7:0]  priority_class,
	output logic [7:0]  protection_level,
	output logic [7:0]  key_select_method,
	output logic [7:0]  key_slot
);
	// Quiet fields until the first request
	initial
	begin
		{data_send_request, source_addr_kind, dest_addr_kind, dest_network_id, dest_node_addr, payload_octet_count,
			payload_tag, send_flags, priority_class, protection_level, key_select_method, key_slot} = '0;
	end
	// Tag, network id and node address are scrambled after the pulse, so a late sample of them shows up
	task automatic send(input logic [1:0] s, d, input logic [7:0] pr, pt, m, k, c, t, input logic a);
		@(posedge clk);
		data_send_request <= 1'b1;
		{source_addr_kind, dest_addr_kind, priority_class, protection_level} <= {s, d, pr, pt};
		{key_select_method, key_slot, payload_tag} <= {m, k, t};
		payload_octet_count <= c;
		send_flags <= {2'b00, a};
		dest_network_id <= 16'hFFFF;
		dest_node_addr <= 64'h0123456789ABCDEF;
		@(posedge clk);
		data_send_request <= 1'b0;
		payload_tag <= ~t;
		dest_network_id <= 16'h0000;
		dest_node_addr <= 64'hFEDCBA9876543210;
	endtask
endmodule // req_source
`default_nettype wire

/* File: data_req_checker_monitor.sv */
// Checker for the request decoder answers.
// Assumes it is bound to data_req_checker; one clock domain.
`default_nettype none
module data_req_checker_monitor
(
	// Clock and reset
	input wire logic        clk,
	input wire logic        arst_n,
	input wire logic        clk_en,
	// Request
	input wire logic        data_send_request,
	input wire logic [1:0]  source_addr_kind,
	input wire logic [1:0]  dest_addr_kind,
	input wire logic [7:0]  payload_tag,
	input wire logic [2:0]  send_flags,
	input wire logic [7:0]  priority_class,
	input wire logic [7:0]  protection_level,
	input wire logic [7:0]  key_slot,
	// Answer
	input wire logic        out_valid,
	input wire logic        out_reject,
	input wire logic [7:0]  out_tag,
	input wire logic [15:0] out_network_id,
	input wire logic        out_ack_mode,
	input wire logic        irq
);
	default clocking @(posedge clk); endclocking
	default disable iff (!arst_n);
	// A request counts only on an enabled edge
	wire logic taken = data_send_request && clk_en;
	a_one_answer: assert property (taken |=> out_valid != out_reject)
		else $error("request not answered once");
	a_idle_quiet: assert property (!data_send_request && clk_en |=> !out_valid && !out_reject)
		else $error("answer without request");
	a_src_reserved: assert property (taken && source_addr_kind == 2'h1 |=> out_reject)
		else $error("reserved source kind accepted");
	a_dst_reserved: assert property (taken && dest_addr_kind == 2'h1 |=> out_reject)
		else $error("reserved destination kind accepted");
	a_net_mask: assert property (out_valid |-> (out_network_id & ~data_req_pkg::NET_ID_MASK) == 16'h0000)
		else $error("network id not masked");
	a_tag_kept: assert property (taken |=> out_tag == $past(payload_tag))
		else $error("tag lost");
	a_ack_bit: assert property (taken |=> !out_valid || out_ack_mode == $past(send_flags[0]))
		else $error("ack mode wrong");
	a_prio_range: assert property (taken && priority_class > 8'h01 |=> out_reject)
		else $error("bad priority accepted");
	a_prot_range: assert property (taken && protection_level != 8'h00 && protection_level != 8'h05 |=> out_reject)
		else $error("bad protection accepted");
	a_slot_range: assert property (taken && key_slot > 8'h01 |=> out_reject)
		else $error("bad key slot accepted");
	c_accept: cover property (out_valid);
	c_reject: cover property (out_reject);
	c_irq: cover property (irq);
endmodule // data_req_checker_monitor
bind data_req_checker data_req_checker_monitor mon_u (.*);
`default_nettype wire

/* File: data_req_checker_bench.sv */
// Bench for the request checker: a table of requests, then hand tests.
// Assumes req_source as the upper layer and the bound monitor.
`default_nettype none
module data_req_checker_bench;
	timeunit 1ns;
	timeprecision 1ps;
	typedef struct {logic [1:0] s, d; logic [7:0] pr, pt, m, k, c; logic a, rej;} row_t;
	logic clk = 1'b0, arst_n = 1'b0, clk_en = 1'b1, reg_write = 1'b0, reg_read = 1'b0;
	logic [3:0] reg_addr = 4'h0;
	logic [31:0] reg_wdata = 32'h0, rd;
	wire logic data_send_request, out_valid, out_reject, out_ack_mode, out_high_prio, out_encrypt, out_key_slot, irq;
	wire logic [1:0] source_addr_kind, dest_addr_kind, out_outcome, out_source_kind, out_dest_kind;
	wire logic [2:0] send_flags;
	wire logic [7:0] payload_octet_count, payload_tag, priority_class, protection_level, key_select_method, key_slot;
	wire logic [7:0] out_tag, out_octet_count;
	wire logic [15:0] dest_network_id, out_network_id;
	wire logic [63:0] dest_node_addr, out_node_addr;
	wire logic [31:0] reg_rdata;
	int num_errors = 0, checked = 0;
	row_t r;
	// Two legal rows, six with one illegal field each, then a legal last row; row 1 hides a bad method behind no protection
	row_t rows [9] = '{'{2'h2, 2'h3, 8'h01, 8'h05, 8'h01, 8'h01, 8'h10, 1'b1, 1'b0},
		'{2'h3, 2'h2, 8'h00, 8'h00, 8'h07, 8'h00, 8'hFF, 1'b0, 1'b0}, '{2'h1, 2'h0, 8'h00, 8'h00, 8'h01, 8'h00, 8'h01, 1'b0, 1'b1},
		'{2'h0, 2'h1, 8'h00, 8'h00, 8'h01, 8'h00, 8'h01, 1'b0, 1'b1}, '{2'h0, 2'h0, 8'h02, 8'h00, 8'h01, 8'h00, 8'h01, 1'b0, 1'b1},
		'{2'h0, 2'h0, 8'h00, 8'h04, 8'h01, 8'h00, 8'h01, 1'b0, 1'b1}, '{2'h0, 2'h0, 8'h00, 8'h05, 8'h00, 8'h00, 8'h01, 1'b0, 1'b1},
		'{2'h0, 2'h0, 8'h00, 8'h00, 8'h01, 8'h02, 8'h01, 1'b0, 1'b1}, '{2'h0, 2'h0, 8'h01, 8'h05, 8'h01, 8'h00, 8'h00, 1'b1, 1'b0}};
	req_source src_u (.*);
	data_req_checker dut_u (.*);
	always #20 clk = ~clk;
	// Node address as the kind should trim it
	function automatic logic [63:0] nexp(logic [1:0] d);
		return d == 2'h3 ? 64'h0123456789ABCDEF : d == 2'h2 ? 64'h000000000000CDEF : 64'h0;
	endfunction
	task automatic check(string n, logic [95:0] e, s);
		checked++;
		if (e !== s)
		begin
			num_errors++;
			$display("mismatch %0s expected %0h seen %0h", n, e, s);
		end
	endtask
	task automatic wr(logic [3:0] a, logic [31:0] d);
		@(posedge clk);
		{reg_addr, reg_wdata, reg_write} <= {a, d, 1'b1};
		@(posedge clk);
		reg_write <= 1'b0;
	endtask
	task automatic rdc(string n, logic [3:0] a, logic [31:0] e);
		@(posedge clk);
		{reg_addr, reg_read} <= {a, 1'b1};
		@(posedge clk);
		reg_read <= 1'b0;
		@(negedge clk);
		check(n, 96'(e), 96'(reg_rdata));
	endtask
	task automatic close_out();
		$display("comparisons %0d mismatches %0d", checked, num_errors);
		if (num_errors == 0 && checked > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	// Main sequence
	initial
	begin
		repeat (20) @(posedge clk);
		arst_n <= 1'b1;
		@(negedge clk);
		check("irq reset", 96'h0, 96'(irq));
		rdc("max reset", data_req_pkg::REG_MAX_PAYLOAD, 32'(data_req_pkg::MAX_PAYLOAD_RESET));
		rdc("unmapped", 4'hF, 32'h0);
		$display("test reset done");
		foreach (rows[i])
		begin
			r = rows[i];
			src_u.send(r.s, r.d, r.pr, r.pt, r.m, r.k, r.c, 8'(i), r.a);
			@(negedge clk);
			check("reject", 96'({r.rej, 1'b0, r.rej}), 96'({out_reject, out_outcome}));
			check("tag", 96'(i), 96'(out_tag));
			if (!r.rej)
				check("decode", {out_source_kind, out_dest_kind, out_network_id, out_node_addr, out_octet_count, out_ack_mode,
					out_high_prio, out_encrypt, out_key_slot}, {r.s, r.d, 16'hFFFF & data_req_pkg::NET_ID_MASK, nexp(r.d),
					r.c, r.a, r.pr[0], r.pt == 8'h05, r.pt == 8'h05 && r.k[0]});
		end
		$display("test table done");
		wr(data_req_pkg::REG_MAX_PAYLOAD, 32'h00000010);
		for (int c = 16; c < 18; c++)
		begin
			src_u.send(2'h0, 2'h0, 8'h00, 8'h00, 8'h01, 8'h00, 8'(c), 8'hA5, 1'b0);
			@(negedge clk);
			check("length", 96'(c == 17), 96'(out_reject));
		end
		@(posedge clk);
		clk_en <= 1'b0;
		src_u.send(2'h0, 2'h0, 8'h00, 8'h00, 8'h01, 8'h00, 8'h01, 8'h3C, 1'b0);
		clk_en <= 1'b1;
		@(negedge clk);
		check("frozen", 96'h0, 96'({out_valid, out_reject}));
		$display("test length done");
		rdc("status", data_req_pkg::REG_STATUS, 32'h00000003);
		wr(data_req_pkg::REG_IRQ_ENABLE, 32'h00000002);
		repeat (2) @(negedge clk);
		check("irq on", 96'h1, 96'(irq));
		wr(data_req_pkg::REG_IRQ_CLEAR, 32'h00000003);
		repeat (2) @(negedge clk);
		check("irq off", 96'h0, 96'(irq));
		rdc("cleared", data_req_pkg::REG_STATUS, 32'h0);
		$display("test irq done");
		close_out();
	end
	// Watchdog, far beyond the roughly 60 cycles the tests need
	initial
	begin
		#100000;
		num_errors++;
		close_out();
	end
endmodule // data_req_checker_bench
`default_nettype wire
